// file: verilog/rcsw_pkg.sv
// Package for the radio core sleep and wake-up controller.
// Assumes a single 40 MHz system clock and a slow timer clock sampled as a pin.
package rcsw_pkg;
	// ====================================================================
	// Field widths and reset values
	localparam int           RCSW_DUR_W       = 32;
	localparam int           RCSW_TW_W        = 10;
	localparam logic [31:0]  RCSW_DUR_RST     = 32'h0000_0000;
	localparam logic [9:0]   RCSW_TW_RST      = 10'h000;
	localparam int           RCSW_SYNC_STAGES = 2;

	// ====================================================================
	// Wake interrupt timing, grouped as software programs it.
	typedef struct packed {
		logic [9:0] lead;
		logic [9:0] release_cnt;
		logic [9:0] ext_width;
	} rcsw_timing_t;

	// Handshake flags coming from software and the power unit.
	typedef struct packed {
		logic sleep_go;
		logic wake_req;
		logic ext_wake_mask;
		logic clk_enabled;
		logic radio_powered;
	} rcsw_ctrl_t;

	typedef enum logic [2:0] {
		RCSW_ACTIVE,
		RCSW_SWITCH,
		RCSW_SLEEP,
		RCSW_EXT_WAKE,
		RCSW_WAIT_PWR
	} rcsw_state_t;
endpackage : rcsw_pkg

// file: verilog/rcsw_slow_tick.sv
// Synchroniser and edge detector for the slow timer clock.
// Assumes the slow clock is far slower than the system clock.
`timescale 1ns/10ps
module rcsw_slow_tick
	import rcsw_pkg::*;
(
	// Clock and reset
	input  wire logic I_MCLK,
	input  wire logic I_RST_B,
	// Slow clock pin and tick
	input  wire logic i_slow_clk,
	output logic      o_tick
);
	logic [RCSW_SYNC_STAGES-1:0] sync_r;
	logic [RCSW_SYNC_STAGES-1:0] sync_nxt;
	logic                        last_r;
	logic                        tick_r;
	logic                        last_nxt;
	logic                        tick_nxt;

	// ====================================================================
	// Only the second stage feeds the edge detector.
	always_comb begin
		sync_nxt = {sync_r[0], i_slow_clk};
		last_nxt = sync_r[1];
		tick_nxt = sync_r[1] & ~last_r;
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_B) begin
			sync_r <= '0;
			last_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			sync_r <= sync_nxt;
			last_r <= last_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;
endmodule : rcsw_slow_tick

// file: verilog/rcsw_core.sv
// Sleep entry and exit controller for the radio baseband core.
// Assumes software drives the control levels synchronously to I_MCLK.
// Functional notes
// - A software wake, or expiry with duration above lead and lead not equal to release, raises the wake interrupt first, then the sleep-exit interrupt.
// - Wake interrupt rises lead slow cycles before the sleep timer expires.
// - Wake interrupt falls release slow cycles before the sleep period ends.
// - On software wake the interrupt stays high for the external-wake width minus release slow cycles.
// - Writing the wake request in the sleep state raises the wake interrupt at once.
// - In sleep the time base runs from the slow clock.
// - Power-off permit rises once the slow clock switch completes.
// - Sleep ends only on timer expiry or software wake request.
// - After expiry the timer waits for power; elapsed count grows.
// - Exit interrupt only from the wait-for-power state, with clocks enabled and radio powered.
// - While wake request is high, sleep entry is refused.
// - The mask bit stops the software wake request from waking the device; sleep entry is still refused.
`timescale 1ns/10ps
module rcsw_core
	import rcsw_pkg::*;
#(
	parameter int DUR_W = RCSW_DUR_W
)(
	// Clock and reset
	input  wire logic                I_MCLK,
	input  wire logic                I_RST_B,
	// Slow timer clock pin
	input  wire logic                I_SLOW_TIMER_CLOCK,
	// Software configuration
	input  wire rcsw_timing_t        I_WAKE_IRQ_TIMING,
	input  wire logic [DUR_W-1:0]    I_SLEEP_DURATION,
	input  wire rcsw_ctrl_t          I_CTRL,
	// Status and interrupts
	output logic                     O_LP_WAKE_IRQ,
	output logic                     O_SLEEP_EXIT_IRQ,
	output logic                     O_RADIO_OFF_PERMIT,
	output logic                     O_IN_SLEEP,
	output logic [DUR_W-1:0]         O_SLEEP_ELAPSED_STATUS
);
	rcsw_state_t      state_r, state_nxt;
	logic [DUR_W-1:0] cnt_r, cnt_nxt;
	logic [DUR_W-1:0] dur_r, dur_nxt;
	logic [9:0]       ext_r, ext_nxt;
	logic             irq_r, irq_nxt;
	logic             exit_r, exit_nxt;
	logic             permit_r, permit_nxt;
	logic [DUR_W-1:0] elapsed_r, elapsed_nxt;
	logic             in_sleep_r, in_sleep_nxt;
	logic             tick;
	logic             wake_evt;
	logic             powered;
	logic [DUR_W-1:0] remain;

	// A tick right after reset is harmless: the active state ignores ticks.
	rcsw_slow_tick u_tick (
		.I_MCLK     (I_MCLK),
		.I_RST_B    (I_RST_B),
		.i_slow_clk (I_SLOW_TIMER_CLOCK),
		.o_tick     (tick)
	);

	// ====================================================================
	// Sleep sequencing.
	always_comb begin
		wake_evt    = I_CTRL.wake_req & ~I_CTRL.ext_wake_mask;
		powered     = I_CTRL.clk_enabled & I_CTRL.radio_powered;
		remain      = (cnt_r < dur_r) ? dur_r - cnt_r : '0;
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		dur_nxt     = dur_r;
		ext_nxt     = ext_r;
		irq_nxt     = irq_r;
		exit_nxt    = 1'b0;
		permit_nxt  = permit_r;
		elapsed_nxt = elapsed_r;
		unique case (state_r)
			RCSW_ACTIVE: begin
				irq_nxt    = 1'b0;
				permit_nxt = 1'b0;
				if (I_CTRL.sleep_go && !I_CTRL.wake_req) begin
					dur_nxt   = I_SLEEP_DURATION;
					cnt_nxt   = '0;
					state_nxt = RCSW_SWITCH;
				end
			end
			RCSW_SWITCH: begin
				// Time base moves to the slow clock on its first edge.
				if (tick) begin
					permit_nxt = 1'b1;
					state_nxt  = RCSW_SLEEP;
				end
			end
			RCSW_SLEEP: begin
				if (wake_evt) begin
					irq_nxt   = 1'b1;
					ext_nxt   = I_WAKE_IRQ_TIMING.ext_width;
					state_nxt = RCSW_EXT_WAKE;
				end else if (tick) begin
					cnt_nxt = cnt_r + 1'b1;
					// Lead and release are measured against the remaining count.
					if (remain - 1'b1 == DUR_W'(I_WAKE_IRQ_TIMING.lead))
						irq_nxt = 1'b1;
					if (remain - 1'b1 == DUR_W'(I_WAKE_IRQ_TIMING.release_cnt))
						irq_nxt = 1'b0;
					if (remain <= 1)
						state_nxt = RCSW_WAIT_PWR;
				end
			end
			RCSW_EXT_WAKE: begin
				if (tick) begin
					cnt_nxt = cnt_r + 1'b1;
					// High for width minus release ticks; a width at or below release drops on the first tick.
					if ({1'b0, ext_r} > {1'b0, I_WAKE_IRQ_TIMING.release_cnt} + 11'h001)
						ext_nxt = ext_r - 1'b1;
					else begin
						irq_nxt   = 1'b0;
						state_nxt = RCSW_WAIT_PWR;
					end
				end
			end
			RCSW_WAIT_PWR: begin
				irq_nxt = 1'b0;
				if (tick && !powered)
					cnt_nxt = cnt_r + 1'b1;
				if (powered) begin
					exit_nxt    = 1'b1;
					permit_nxt  = 1'b0;
					elapsed_nxt = cnt_r;
					state_nxt   = RCSW_ACTIVE;
				end
			end
		endcase
		// Registered so that the status output comes straight from a flip-flop.
		in_sleep_nxt = (state_nxt != RCSW_ACTIVE);
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_B) begin
			state_r   <= RCSW_ACTIVE;
			cnt_r     <= RCSW_DUR_RST;
			dur_r     <= RCSW_DUR_RST;
			ext_r     <= RCSW_TW_RST;
			irq_r     <= 1'b0;
			exit_r    <= 1'b0;
			permit_r  <= 1'b0;
			elapsed_r <= RCSW_DUR_RST;
			in_sleep_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			dur_r     <= dur_nxt;
			ext_r     <= ext_nxt;
			irq_r     <= irq_nxt;
			exit_r    <= exit_nxt;
			permit_r  <= permit_nxt;
			elapsed_r <= elapsed_nxt;
			in_sleep_r <= in_sleep_nxt;
		end
	end

	assign O_LP_WAKE_IRQ          = irq_r;
	assign O_SLEEP_EXIT_IRQ       = exit_r;
	assign O_RADIO_OFF_PERMIT     = permit_r;
	assign O_IN_SLEEP             = in_sleep_r;
	assign O_SLEEP_ELAPSED_STATUS = elapsed_r;

	// ====================================================================
	// Checks.
	// Remembers whether a wake interrupt was seen during the current sleep.
	logic seen_wake_r;
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_B || state_r == RCSW_ACTIVE)
			seen_wake_r <= 1'b0;
		else if (irq_r)
			seen_wake_r <= 1'b1;
	end

	exit_after_wake_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		exit_nxt |-> seen_wake_r) else $error("Exit interrupt without prior wake interrupt.");
	exit_needs_pwr_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		exit_nxt |-> powered && state_r == RCSW_WAIT_PWR) else $error("Exit without power.");
	wake_req_irq_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_SLEEP && wake_evt |=> O_LP_WAKE_IRQ) else $error("Wake request ignored.");
	no_entry_req_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_ACTIVE && I_CTRL.wake_req |=> state_r == RCSW_ACTIVE)
		else $error("Sleep entered with wake request high.");
	mask_ignores_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_SLEEP && I_CTRL.ext_wake_mask && !tick |=> state_r == RCSW_SLEEP)
		else $error("Masked wake request acted on.");
	permit_on_tick_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		$rose(O_RADIO_OFF_PERMIT) |-> $past(state_r) == RCSW_SWITCH)
		else $error("Permit raised outside the clock switch.");
	elapsed_capture_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		exit_nxt |=> O_SLEEP_ELAPSED_STATUS == $past(cnt_r))
		else $error("Elapsed count not captured.");
	wait_holds_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_WAIT_PWR && !powered |=> state_r == RCSW_WAIT_PWR)
		else $error("Left sleep while unpowered.");
	// The properties below watch the sleep state from the outside of the sequencer.
	irq_low_wait_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_WAIT_PWR && $past(state_r) == RCSW_WAIT_PWR |-> !O_LP_WAKE_IRQ)
		else $error("Wake interrupt still high while waiting for power.");
	permit_in_sleep_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_SLEEP |-> O_RADIO_OFF_PERMIT)
		else $error("Power-off permit low during sleep.");
	count_on_tick_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_SLEEP && !tick |=> $stable(cnt_r))
		else $error("Sleep count moved without a slow tick.");
	sleep_stays_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_SLEEP && !wake_evt && !tick |=> state_r == RCSW_SLEEP)
		else $error("Sleep left without expiry or wake request.");
	no_exit_unpwr_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		state_r == RCSW_WAIT_PWR && !powered |=> !O_SLEEP_EXIT_IRQ)
		else $error("Exit interrupt while unpowered.");
endmodule : rcsw_core

// file: tb/rcsw_host_model.sv
// Host software and power unit model that gates and restores the core clocks and radio power.
// Assumes it is clocked by I_MCLK and sees the wake interrupt and power-off permit of the core.
`timescale 1ns/10ps
module rcsw_host_model
	import rcsw_pkg::*;
(
	// Clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RST_B,
	// Core status and handler delay
	input  wire logic        i_irq,
	input  wire logic        i_permit,
	input  wire logic [15:0] i_dly,
	// Power controls
	output logic             o_clk_en,
	output logic             o_radio_pwr
);
	logic        irq_q;
	logic        perm_q;
	logic [15:0] cnt;
	// ====================================================================
	// Handler: power returns i_dly cycles after the wake interrupt falls.
	always @(posedge I_MCLK) begin
		irq_q  <= i_irq;
		perm_q <= i_permit;
		if (!I_RST_B) begin
			o_clk_en    <= 1'b1;
			o_radio_pwr <= 1'b1;
			cnt         <= 16'h0000;
		end else if (irq_q && !i_irq) begin
			cnt <= i_dly;
		end else if (cnt == 16'h0001) begin
			o_clk_en    <= 1'b1;
			o_radio_pwr <= 1'b1;
			cnt         <= 16'h0000;
		end else if (cnt > 16'h0001) begin
			cnt <= cnt - 16'h0001;
		end else if (i_permit && !perm_q) begin
			o_clk_en    <= 1'b0;
			o_radio_pwr <= 1'b0;
		end
	end
endmodule : rcsw_host_model

// file: tb/tb_top.sv
// Self-checking bench for the radio core sleep controller.
// Assumes a free-running slow clock far slower than I_MCLK.
`timescale 1ns/10ps
`define CHK(nm,e,a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp=%0h got=%0h", nm, e, a); end end
module tb_top
	import rcsw_pkg::*;
;
	logic         I_MCLK  = 1'b0;
	logic         I_RST_B = 1'b0;
	logic         slow    = 1'b0;
	logic         go, wreq, msk, cen, rpw, irq, ex, perm, insl, irq_q, seen, ord;
	logic [15:0]  dly;
	logic [31:0]  dur, el;
	rcsw_timing_t tim;
	rcsw_ctrl_t   ctl;
	int           error_cnt = 0;
	int           n_checks  = 0;
	int           sc = 0;
	int           ar, af, k;
	int           seed = 61686;
	assign ctl = {go, wreq, msk, cen, rpw};
	rcsw_core i_dut (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_SLOW_TIMER_CLOCK(slow),
		.I_WAKE_IRQ_TIMING(tim), .I_SLEEP_DURATION(dur), .I_CTRL(ctl),
		.O_LP_WAKE_IRQ(irq), .O_SLEEP_EXIT_IRQ(ex), .O_RADIO_OFF_PERMIT(perm),
		.O_IN_SLEEP(insl), .O_SLEEP_ELAPSED_STATUS(el));
	rcsw_host_model i_host (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .i_irq(irq),
		.i_permit(perm), .i_dly(dly), .o_clk_en(cen), .o_radio_pwr(rpw));
	// ====================================================================
	// Clocks and monitor; the slow clock is shortened to 80 cycles.
	initial forever #12.5 I_MCLK = ~I_MCLK;
	initial forever #1000 slow = ~slow;
	always @(posedge slow) sc++;
	always @(posedge I_MCLK) begin
		irq_q <= irq;
		if (irq && !irq_q) begin
			ar   = sc;
			seen = 1'b1;
		end
		if (!irq && irq_q) af = sc;
		if (ex) ord = seen;
	end
	task summarize;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// ====================================================================
	// One sleep period, ended by the timer or by a software wake request.
	task do_sleep(input bit ext, input bit mk);
		logic [31:0] r;
		logic [9:0]  lv, w;
		logic [31:0] d;
		r  = $random(seed);
		lv = 10'h002 + r[1:0];
		w  = 10'h002 + r[3:2];
		d  = ext ? (mk ? lv + 6 : 32'h28) : lv + 2 + r[6:4];
		@(posedge I_MCLK);
		tim <= {lv, 10'h001, w};
		dur <= d;
		msk <= mk;
		@(posedge I_MCLK);
		go   <= 1'b1;
		seen = 1'b0;
		ord  = 1'b0;
		for (k = 0; insl !== 1'b1 && k < 10; k++) @(posedge I_MCLK) #1;
		`CHK("in_sleep", 1'b1, insl)
		@(posedge I_MCLK) go <= 1'b0;
		for (k = 0; perm !== 1'b1 && k < 400; k++) @(posedge I_MCLK) #1;
		`CHK("permit_on", 1'b1, perm)
		if (ext) begin
			repeat (100) @(posedge I_MCLK);
			wreq <= 1'b1;
			@(posedge I_MCLK) wreq <= 1'b0;
			repeat (2) @(posedge I_MCLK);
			#1 `CHK("wake_irq", ~mk, irq)
		end
		for (k = 0; ex !== 1'b1 && k < 3000; k++) @(posedge I_MCLK) #1;
		`CHK("exit_irq", 1'b1, ex)
		@(posedge I_MCLK) #1;
		`CHK("irq_order", 1'b1, ord)
		`CHK("permit_off", 1'b0, perm)
		`CHK("irq_ticks", (ext && !mk) ? w - 1 : lv - 1, af - ar)
		`CHK("elapsed", !(ext && !mk), el > d - (dly < 150))
	endtask : do_sleep
	// ====================================================================
	// Main sequence and watchdog.
	initial begin
		{go, wreq, msk} = 3'h0;
		tim = '0;
		dur = 32'h0;
		dly = 16'h00fa;
		repeat (16) @(posedge I_MCLK);
		I_RST_B <= 1'b1;
		@(posedge I_MCLK);
		wreq <= 1'b1;
		go   <= 1'b1;
		repeat (4) @(posedge I_MCLK);
		`CHK("refused", 2'h0, {insl, irq})
		go   <= 1'b0;
		wreq <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			@(posedge I_MCLK) dly <= i[0] ? 16'h0014 : 16'h00fa;
			do_sleep(i >= 2, i >= 4);
		end
		summarize();
	end
	initial begin
		#(25 * 60000);
		error_cnt++;
		summarize();
	end
endmodule : tb_top
